// File: verilog/fast_ethernet_rx_pcs.sv
// receive coding path: MLT-3 symbols in, MII nibbles out
//
// How it works
// RULE1 - link pulses never raise signal detect
// RULE2 - three-level symbols become NRZI bits
// RULE3 - NRZI transitions become NRZ ones
// RULE4 - bits are grouped into 5-bit symbols
// RULE5 - descrambled bit is received XOR key
// RULE6 - lock after twelve unscrambled idle groups
// RULE7 - hold timer restarts on 58 idle bits
// RULE8 - hold expiry drops lock, resets descrambler
// RULE9 - aligner input bypasses descrambler when asked
// RULE10 - J/K pair fixes the group boundary
// RULE11 - lookup maps each group to nibble
// RULE12 - J/K replaced by two preamble nibbles
// RULE13 - T/R or two idles end packet
// RULE14 - signal detect held 395 us for link
// RULE15 - idle to non-J/K is bad start
// RULE16 - bad start sends error nibble 1110
// RULE17 - bad start counts false carrier once
// RULE18 - two idles clear error and carrier
// RULE19 - control groups idle, J, K, T, R, halt
// RULE20 - standard sixteen data code-groups
// RULE21 - key from 11-bit closed-loop LFSR
// RULE22 - lost link, or lost lock with bypass off, clears alignment
// RULE23 - one nibble per MII receive clock
`timescale 1ns/1ps
`include "rx_pcs_params.svh"
module fast_ethernet_rx_pcs #(
  parameter int HOLD_CYCLES = `RX_HOLD_CYC,
  parameter int LINK_CYCLES = `RX_LINK_CYC,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // equalized symbols: 2'b00 zero, 2'b01 plus, 2'b11 minus
  input wire logic sym_valid,
  input wire logic [1:0] sym_level,
  // pins
  input wire logic energy_raw,
  input wire logic descr_bypass_raw,
  // status
  output logic signal_detect_q,
  output logic link_up_q,
  output logic descr_locked_q,
  output logic [CNT_W-1:0] false_carrier_event_counter_q,
  // MII receive side
  output logic mii_rx_clk_q,
  output logic [3:0] rxd_q,
  output logic rx_dv_q,
  output logic rx_er_q,
  output logic crs_q
);
  import rx_pcs_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int LW = $clog2(LINK_CYCLES + 1);
  localparam int QW = $clog2(`RX_SD_QUAL_CYC + 1);

  generate
    if (HOLD_CYCLES < 1 || LINK_CYCLES < 1 || CNT_W < 1) begin : g_bad_param
      $error("fast_ethernet_rx_pcs needs positive counts and counter width");
    end
  endgenerate

  // ----------------------------------------
  // code-group lookup
  // ----------------------------------------
  // returns {data_valid, nibble}
  function automatic logic [4:0] cg_decode(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    case (cg)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] en_sync_q;
  logic [2:0] byp_sync_q;
  logic energy_q;
  logic bypass_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_sync_q <= 3'h0;
      byp_sync_q <= 3'h0;
      energy_q <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      en_sync_q <= {en_sync_q[1:0], energy_raw};
      byp_sync_q <= {byp_sync_q[1:0], descr_bypass_raw};
      if (en_sync_q[1] == en_sync_q[2]) energy_q <= en_sync_q[2];
      if (byp_sync_q[1] == byp_sync_q[2]) bypass_q <= byp_sync_q[2];
    end
  end

  // ----------------------------------------
  // signal detect and link monitor
  // ----------------------------------------
  logic [QW-1:0] qual_cnt_q;
  logic [LW-1:0] link_cnt_q;

  // short link pulses never last the qualify time
  wire qual_done = (qual_cnt_q == QW'(`RX_SD_QUAL_CYC));
  wire link_done = (link_cnt_q == LW'(LINK_CYCLES));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      qual_cnt_q <= '0;
      signal_detect_q <= 1'b0;
      link_cnt_q <= '0;
      link_up_q <= 1'b0;
    end else begin
      if (!energy_q) qual_cnt_q <= '0;
      else if (!qual_done) qual_cnt_q <= qual_cnt_q + 1'b1;
      signal_detect_q <= energy_q && qual_done; // [RULE1]
      if (!signal_detect_q) link_cnt_q <= '0;
      else if (!link_done) link_cnt_q <= link_cnt_q + 1'b1;
      link_up_q <= signal_detect_q && link_done; // [RULE14]
    end
  end

  // ----------------------------------------
  // line decode and descrambler
  // ----------------------------------------
  logic nrzi_prev_q;
  logic [10:0] lfsr_q;
  logic [5:0] match_cnt_q;
  logic [5:0] ones_run_q;
  logic [HW-1:0] hold_cnt_q;

  wire nrzi_bit = (sym_level != 2'b00); // [RULE2]
  wire nrz_bit = nrzi_bit ^ nrzi_prev_q; // [RULE3]
  wire key_bit = lfsr_q[`RX_LFSR_TAP_A] ^ lfsr_q[`RX_LFSR_TAP_B]; // [RULE21]
  wire ud_bit = nrz_bit ^ key_bit; // [RULE5]
  wire lock_now = descr_locked_q || bypass_q;
  wire line_bit = bypass_q ? nrz_bit : ud_bit; // [RULE9]
  wire [5:0] ones_next = line_bit ? ((ones_run_q == 6'h3F) ? ones_run_q : ones_run_q + 6'h01) : 6'h00;
  // a long idle run keeps refreshing, so steady idle never lets the hold timer run out
  wire hold_refresh = sym_valid && (ones_next >= `RX_IDLE_HOLD_BITS); // [RULE7]
  wire hold_expired = descr_locked_q && (hold_cnt_q == '0);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nrzi_prev_q <= 1'b0;
      lfsr_q <= 11'h000;
      match_cnt_q <= 6'h00;
      descr_locked_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (hold_expired || !link_up_q) begin
      descr_locked_q <= 1'b0; // [RULE8]
      lfsr_q <= 11'h000;
      match_cnt_q <= 6'h00;
      if (sym_valid) nrzi_prev_q <= nrzi_bit;
    end else begin
      if (sym_valid) begin
        nrzi_prev_q <= nrzi_bit;
        if (descr_locked_q) begin
          lfsr_q <= {lfsr_q[9:0], key_bit};
        end else begin
          // idle assumed: key equals inverted line bit
          lfsr_q <= {lfsr_q[9:0], ~nrz_bit};
          if (key_bit == ~nrz_bit) match_cnt_q <= match_cnt_q + 6'h01;
          else match_cnt_q <= 6'h00;
          if (key_bit == ~nrz_bit && match_cnt_q == `RX_IDLE_SYNC_BITS - 6'h01) begin
            descr_locked_q <= 1'b1; // [RULE6]
            hold_cnt_q <= HW'(HOLD_CYCLES); // [RULE7]
          end
        end
      end
      if (descr_locked_q) begin
        if (hold_refresh) hold_cnt_q <= HW'(HOLD_CYCLES); // [RULE7]
        else hold_cnt_q <= hold_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // alignment and code-group state machine
  // ----------------------------------------
  rx_state_type state_q;
  logic [9:0] sreg_q;
  logic [2:0] gcnt_q;
  logic [2:0] zcnt_q;
  logic idle_cnt_q;
  logic t_seen_q;
  logic push_v_q;
  logic pre2_q;
  nib_entry_type push_d_q;

  nib_stream_if #(.W(6)) buf_in ();
  nib_stream_if #(.W(6)) buf_out ();

  wire run = link_up_q && lock_now;
  wire [9:0] window = {sreg_q[8:0], line_bit};
  wire [4:0] group = window[4:0];
  wire group_done = sym_valid && (gcnt_q == 3'h4); // [RULE4]
  wire jk_hit = (window == `RX_JK_PAIR); // [RULE10]
  wire is_idle = (group == `RX_CG_IDLE); // [RULE19]
  wire is_t = (group == `RX_CG_T);
  wire is_r = (group == `RX_CG_R);
  wire [4:0] dec = cg_decode(group); // [RULE11] [RULE20]
  wire second_idle = group_done && is_idle && idle_cnt_q;
  wire bad_start = sym_valid && (state_q == ST_IDLE) && !jk_hit && (zcnt_q == `RX_JK_LAST_BIT);
  wire accepted = push_v_q && buf_in.ready;

  assign buf_in.valid = push_v_q;
  assign buf_in.data = push_d_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_HUNT;
      sreg_q <= 10'h000;
      gcnt_q <= 3'h0;
      zcnt_q <= 3'h0;
      idle_cnt_q <= 1'b0;
      t_seen_q <= 1'b0;
      ones_run_q <= 6'h00;
      false_carrier_event_counter_q <= '0;
    end else if (!run) begin
      state_q <= ST_HUNT; // [RULE22]
      gcnt_q <= 3'h0;
      zcnt_q <= 3'h0;
      ones_run_q <= 6'h00;
    end else if (sym_valid) begin
      sreg_q <= window;
      ones_run_q <= ones_next;
      gcnt_q <= (gcnt_q == 3'h4) ? 3'h0 : gcnt_q + 3'h1;
      case (state_q)
        ST_HUNT: begin
          zcnt_q <= 3'h0;
          if (ones_next >= `RX_IDLE_RUN_BITS) state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          idle_cnt_q <= 1'b0;
          t_seen_q <= 1'b0;
          if (jk_hit) begin
            state_q <= ST_DATA; // [RULE10]
            gcnt_q <= 3'h0;
            zcnt_q <= 3'h0;
          end else if (bad_start) begin
            state_q <= ST_BAD; // [RULE15]
            gcnt_q <= 3'h0;
            zcnt_q <= 3'h0;
            false_carrier_event_counter_q <= false_carrier_event_counter_q + 1'b1; // [RULE17]
          end else if (zcnt_q != 3'h0 || !line_bit) begin
            zcnt_q <= zcnt_q + 3'h1;
          end
        end
        ST_DATA: begin
          if (group_done) begin
            idle_cnt_q <= is_idle;
            if (second_idle || (t_seen_q && is_r)) state_q <= ST_HUNT; // [RULE13]
            t_seen_q <= is_t && !t_seen_q;
          end
        end
        default: begin
          if (group_done) begin
            idle_cnt_q <= is_idle;
            if (second_idle) state_q <= ST_HUNT; // [RULE18]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // nibble hand-off into the buffer
  // ----------------------------------------
  wire data_push = (state_q == ST_DATA) && group_done && !is_idle && !(t_seen_q && is_r) && !(is_t && !t_seen_q);
  wire bad_push = (state_q == ST_BAD) && group_done && !second_idle;
  wire jk_push = (state_q == ST_IDLE) && sym_valid && jk_hit;
  wire do_push = run && (data_push || bad_push || jk_push);
  wire [5:0] data_entry = {1'b1, !dec[4], dec[3:0]};
  wire [5:0] bad_entry = {2'b01, `RX_NIB_BAD_START_OF_STREAM}; // [RULE16]
  wire [5:0] pre_entry = {2'b10, `RX_NIB_PREAMBLE}; // [RULE12]
  wire [5:0] push_sel = jk_push ? pre_entry : (bad_push ? bad_entry : data_entry);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      push_v_q <= 1'b0;
      push_d_q <= 6'h00;
      pre2_q <= 1'b0;
    end else if (do_push) begin
      push_v_q <= 1'b1;
      push_d_q <= push_sel;
      pre2_q <= jk_push; // [RULE12]
    end else if (accepted) begin
      push_v_q <= pre2_q;
      pre2_q <= 1'b0;
    end
  end

  nib_buffer #(.WIDTH(6), .DEPTH(2)) u_buf (
    .clk(core_clk),
    .rst_n(nrst),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  // ----------------------------------------
  // MII output at one nibble per receive clock
  // ----------------------------------------
  logic [1:0] div_q;
  wire mii_tick = (div_q == 2'(`RX_MII_DIV - 1));
  assign buf_out.ready = mii_tick; // [RULE23]
  wire pop = mii_tick && buf_out.valid;
  wire busy = (state_q == ST_DATA) || (state_q == ST_BAD);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 2'h0;
      mii_rx_clk_q <= 1'b0;
      rxd_q <= 4'h0;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
      crs_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      // falls on the tick, so each nibble is mid-period at the rising edge
      mii_rx_clk_q <= div_q[0] ^ div_q[1];
      if (mii_tick) begin
        rxd_q <= pop ? buf_out.data[3:0] : 4'h0;
        rx_dv_q <= pop && buf_out.data[5];
        rx_er_q <= pop && buf_out.data[4]; // [RULE16] [RULE18]
        crs_q <= busy || pop || buf_out.valid; // [RULE18]
      end
    end
  end

endmodule

// File: pkg/rx_pcs_params.svh
// constants for the 100 Mb/s receive coding path
`ifndef RX_PCS_PARAMS_SVH
`define RX_PCS_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RX_CLK_MHZ 100
`define RX_HOLD_TIME_US 722
`define RX_LINK_TIME_US 395
`define RX_SD_QUAL_NS 1000
`define RX_HOLD_CYC (`RX_HOLD_TIME_US * `RX_CLK_MHZ)
`define RX_LINK_CYC (`RX_LINK_TIME_US * `RX_CLK_MHZ)
`define RX_SD_QUAL_CYC ((`RX_SD_QUAL_NS * `RX_CLK_MHZ + 999) / 1000)
`define RX_MII_DIV 4

// ----------------------------------------
// descrambler and alignment counts
// ----------------------------------------
`define RX_IDLE_SYNC_BITS 6'h3C
`define RX_IDLE_HOLD_BITS 6'h3A
`define RX_IDLE_RUN_BITS 6'h0A
`define RX_JK_LAST_BIT 3'h7
`define RX_LFSR_TAP_A 10
`define RX_LFSR_TAP_B 8

// ----------------------------------------
// code-groups and special nibbles
// ----------------------------------------
`define RX_CG_IDLE 5'h1F
`define RX_CG_J 5'h18
`define RX_CG_K 5'h11
`define RX_CG_T 5'h0D
`define RX_CG_R 5'h07
`define RX_CG_HALT 5'h04
`define RX_JK_PAIR 10'h311
`define RX_NIB_PREAMBLE 4'h5
`define RX_NIB_BAD_START_OF_STREAM 4'hE

`endif

// File: pkg/rx_pcs_pkg.sv
// types shared by the receive coding path
package rx_pcs_pkg;

  typedef enum logic [3:0] {
    ST_HUNT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_DATA = 4'b0100,
    ST_BAD = 4'b1000
  } rx_state_type;

  // buffer entry: {rx_dv, rx_er, nibble}
  typedef logic [5:0] nib_entry_type;

endpackage

// File: pkg/nib_stream_if.sv
// valid/ready stream carrying decoded nibbles
`timescale 1ns/1ps
interface nib_stream_if #(parameter int W = 6) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verilog/nib_buffer.sv
// small valid/ready buffer between decoder and MII output
`timescale 1ns/1ps
module nib_buffer #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill and drain sides
  nib_stream_if.snk in_s,
  nib_stream_if.src out_s
);

  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("nib_buffer depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;

  wire full = (cnt_q == (AW + 1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire do_wr = in_s.valid && !full;
  wire do_rd = out_s.ready && !empty;

  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) wr_q <= wr_q + 1'b1;
      if (do_rd) rd_q <= rd_q + 1'b1;
      if (do_wr && !do_rd) cnt_q <= cnt_q + 1'b1;
      else if (do_rd && !do_wr) cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// File: tb/rx_pcs_assertions.sv
// port-level checks for the receive coding path
`timescale 1ns/1ps
module rx_pcs_checker #(
  parameter int LINK_CYCLES = 50,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // line and status
  input wire logic energy_raw,
  input wire logic signal_detect_q,
  input wire logic link_up_q,
  input wire logic descr_locked_q,
  input wire logic [CNT_W-1:0] false_carrier_event_counter_q,
  // mii receive
  input wire logic mii_rx_clk_q,
  input wire logic [3:0] rxd_q,
  input wire logic rx_dv_q,
  input wire logic rx_er_q,
  input wire logic crs_q
);
  localparam int SD_QUAL = 100;
  int en_run_q;
  int sd_run_q;
  // a frame has already opened within this carrier span
  logic framed_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // --------------------------------
  // run-length helpers
  // --------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_run_q <= 0;
      sd_run_q <= 0;
      framed_q <= 1'b0;
    end else begin
      en_run_q <= energy_raw ? en_run_q + 1 : 0;
      sd_run_q <= signal_detect_q ? sd_run_q + 1 : 0;
      framed_q <= crs_q && (framed_q || rx_dv_q);
    end
  end

  // --------------------------------
  // assertions
  // --------------------------------
  a_detect_qualify: assert property ($rose(signal_detect_q) |-> en_run_q >= SD_QUAL)
    else $error("signal detect rose before qualify time");
  a_link_delay: assert property ($rose(link_up_q) |-> sd_run_q >= LINK_CYCLES - 1)
    else $error("link up before detect held long enough");
  a_link_drop: assert property (!signal_detect_q |=> !link_up_q)
    else $error("link stayed up without signal detect");
  a_fcc_step: assert property (!$stable(false_carrier_event_counter_q) |->
    false_carrier_event_counter_q == $past(false_carrier_event_counter_q) + 1'b1)
    else $error("false carrier counter moved by other than one");
  a_mii_period: assert property ($rose(mii_rx_clk_q) |=> mii_rx_clk_q ##1 !mii_rx_clk_q ##1 !mii_rx_clk_q
    ##1 mii_rx_clk_q)
    else $error("receive clock not a four cycle square wave");
  a_mii_hold: assert property (!$stable({rxd_q, rx_dv_q, rx_er_q, crs_q}) |-> $fell(mii_rx_clk_q))
    else $error("mii outputs changed off the tick");
  a_preamble_pair: assert property ($rose(rx_dv_q) && !framed_q |->
    rxd_q == 4'h5 && !rx_er_q ##4 rx_dv_q && rxd_q == 4'h5)
    else $error("frame does not open with two preamble nibbles");
  a_bad_nibble: assert property (rx_er_q && !rx_dv_q |-> rxd_q == 4'hE && crs_q)
    else $error("false carrier nibble wrong");
  a_unlinked_quiet: assert property ((!link_up_q) [*8] ##1 (!link_up_q) [*8] |-> !rx_dv_q)
    else $error("data delivered while link down");
  a_carrier_frame: assert property (rx_dv_q |-> crs_q)
    else $error("carrier low inside frame");

  c_frame: cover property ($rose(rx_dv_q));
  c_false_carrier: cover property (!$stable(false_carrier_event_counter_q));
  c_lock_lost: cover property ($fell(descr_locked_q));
endmodule

bind fast_ethernet_rx_pcs rx_pcs_checker #(.LINK_CYCLES(LINK_CYCLES), .CNT_W(CNT_W)) chk (
  .core_clk(core_clk), .nrst(nrst), .energy_raw(energy_raw), .signal_detect_q(signal_detect_q),
  .link_up_q(link_up_q), .descr_locked_q(descr_locked_q),
  .false_carrier_event_counter_q(false_carrier_event_counter_q), .mii_rx_clk_q(mii_rx_clk_q),
  .rxd_q(rxd_q), .rx_dv_q(rx_dv_q), .rx_er_q(rx_er_q), .crs_q(crs_q));

// File: tb/mii_mac_model.sv
// receiving mac model: samples mii nibbles on the receive clock rising edge
`timescale 1ns/1ps
module mii_mac_model (
  // mii receive
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er
);
  logic [3:0] got[$];
  int bad = 0;

  always @(posedge rx_clk) begin
    if (rx_dv === 1'b1) begin
      got.push_back(rxd);
    end
    if (rx_er === 1'b1 && rx_dv === 1'b0 && rxd === 4'hE) begin
      bad++;
    end
  end
endmodule

// File: tb/fast_ethernet_rx_pcs_tb.sv
// self-checking bench for the receive coding path
`timescale 1ns/1ps
module fast_ethernet_rx_pcs_tb;
  // --------------------------------
  // signals and line encoder state
  // --------------------------------
  logic core_clk, nrst, sym_valid, energy_raw, descr_bypass_raw;
  logic [1:0] sym_level;
  logic signal_detect_q, link_up_q, descr_locked_q, mii_rx_clk_q, rx_dv_q, rx_er_q, crs_q;
  logic [15:0] false_carrier_event_counter_q;
  logic [3:0] rxd_q;
  logic nrzi, pol, scr;
  logic [10:0] lfsr;
  int errors, samples_checked;
  localparam logic [4:0] CODES [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  fast_ethernet_rx_pcs #(.HOLD_CYCLES(300), .LINK_CYCLES(50), .CNT_W(16)) dut (
    .core_clk(core_clk), .nrst(nrst), .sym_valid(sym_valid), .sym_level(sym_level),
    .energy_raw(energy_raw), .descr_bypass_raw(descr_bypass_raw), .signal_detect_q(signal_detect_q),
    .link_up_q(link_up_q), .descr_locked_q(descr_locked_q),
    .false_carrier_event_counter_q(false_carrier_event_counter_q), .mii_rx_clk_q(mii_rx_clk_q),
    .rxd_q(rxd_q), .rx_dv_q(rx_dv_q), .rx_er_q(rx_er_q), .crs_q(crs_q));

  mii_mac_model mac (.rx_clk(mii_rx_clk_q), .rxd(rxd_q), .rx_dv(rx_dv_q), .rx_er(rx_er_q));

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic compare_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    errors++;
    $display("mismatch at %0t: timeout waiting for %s", $time, what);
    end_of_test();
  endtask

  // scrambles when asked, then nrzi and three-level coding, msb first
  task automatic send_group(input logic [4:0] g);
    logic b;
    for (int i = 4; i >= 0; i--) begin
      b = g[i] ^ (scr & (lfsr[10] ^ lfsr[8]));
      lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
      nrzi = nrzi ^ b;
      pol = (nrzi && b) ? !pol : pol;
      @(posedge core_clk);
      sym_valid <= 1'b1;
      sym_level <= !nrzi ? 2'b00 : (pol ? 2'b11 : 2'b01);
    end
  endtask

  task automatic quiet(input int n);
    @(posedge core_clk);
    sym_valid <= 1'b0;
    repeat (n) @(negedge core_clk);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_link();
    int n;
    compare_val(false_carrier_event_counter_q, 16'h0, "counter after reset");
    @(posedge core_clk);
    energy_raw <= 1'b1;
    repeat (20) @(posedge core_clk);
    energy_raw <= 1'b0;
    repeat (30) @(negedge core_clk);
    compare_val(16'(signal_detect_q), 16'h0, "short burst detect");
    @(posedge core_clk);
    energy_raw <= 1'b1;
    for (n = 0; n < 400 && link_up_q !== 1'b1; n++) @(negedge core_clk);
    if (link_up_q !== 1'b1) give_up("link");
    compare_val(16'(n >= 150), 16'h1, "link delay");
    $display("t_link done");
  endtask

  task automatic t_lock();
    int n;
    scr = 1'b1;
    repeat (11) send_group(5'h1F);
    @(negedge core_clk);
    compare_val(16'(descr_locked_q), 16'h0, "early lock");
    repeat (5) send_group(5'h1F);
    quiet(3);
    compare_val(16'(descr_locked_q), 16'h1, "lock");
    repeat (70) send_group(5'h1F);
    quiet(3);
    compare_val(16'(descr_locked_q), 16'h1, "lock kept by idle");
    for (n = 0; n < 600 && descr_locked_q === 1'b1; n++) @(negedge core_clk);
    compare_val(16'(n > 200 && n < 600), 16'h1, "hold expiry");
    scr = 1'b0;
    $display("t_lock done");
  endtask

  task automatic t_packet();
    @(posedge core_clk);
    descr_bypass_raw <= 1'b1;
    repeat (10) @(posedge core_clk);
    mac.got.delete();
    repeat (6) send_group(5'h1F);
    send_group(5'h18);
    send_group(5'h11);
    foreach (CODES[i]) send_group(CODES[i]);
    send_group(5'h0D);
    send_group(5'h07);
    repeat (4) send_group(5'h1F);
    quiet(40);
    compare_val(16'(mac.got.size()), 16'd18, "nibble count");
    foreach (mac.got[i]) compare_val({12'h0, mac.got[i]}, (i < 2) ? 16'h5 : 16'(i - 2), "nibble");
    compare_val({15'h0, crs_q}, 16'h0, "carrier after end");
    $display("t_packet done");
  endtask

  task automatic t_bad();
    logic [15:0] c;
    c = false_carrier_event_counter_q;
    mac.got.delete();
    mac.bad = 0;
    repeat (6) send_group(5'h1F);
    send_group(5'h0E);
    send_group(5'h0E);
    repeat (4) send_group(5'h1F);
    quiet(40);
    compare_val(false_carrier_event_counter_q, c + 16'h1, "false carrier count");
    compare_val(16'(mac.bad > 0), 16'h1, "error nibbles");
    compare_val(16'(mac.got.size()), 16'h0, "no data nibbles");
    compare_val({14'h0, rx_er_q, crs_q}, 16'h0, "error and carrier cleared");
    $display("t_bad done");
  endtask

  task automatic t_drop();
    @(posedge core_clk);
    energy_raw <= 1'b0;
    repeat (20) @(negedge core_clk);
    compare_val(16'(link_up_q), 16'h0, "link after energy loss");
    mac.got.delete();
    repeat (6) send_group(5'h1F);
    send_group(5'h18);
    send_group(5'h11);
    repeat (2) send_group(CODES[5]);
    quiet(40);
    compare_val(16'(mac.got.size()), 16'h0, "data without link");
    $display("t_drop done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    nrst = 1'b0;
    sym_valid = 1'b0;
    sym_level = 2'b00;
    energy_raw = 1'b0;
    descr_bypass_raw = 1'b0;
    nrzi = 1'b0;
    pol = 1'b0;
    scr = 1'b0;
    lfsr = 11'h5A5;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge core_clk);
    t_link();
    t_lock();
    t_packet();
    t_bad();
    t_drop();
    end_of_test();
  end
endmodule
